/* File: hdl/msa_pkg.sv */
// Purpose: Shared constants and carriers for the station address and deferral control block.
// Assumes: 40 MHz core clock, 32-bit Avalon-MM register access.
// Notes: Register offsets are word indices; byte address is four times the index.
package msa_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    localparam logic [3:0] IDX_CONTROL = 4'h1;
    localparam logic [3:0] IDX_ADDR_UPPER = 4'h2;
    localparam logic [3:0] IDX_ADDR_LOWER = 4'h3;
    localparam logic [3:0] IDX_IRQ_STATUS = 4'h4;
    localparam logic [3:0] IDX_IRQ_MASK = 4'h5;
    localparam logic [31:0] UPPER_RESET = 32'h0000FFFF;
    localparam logic [31:0] LOWER_RESET = 32'h0FFFFFFF;
    localparam logic [31:0] UPPER_USED = 32'h0000FFFF;
    localparam int unsigned CTL_RX_BIT = 2;
    localparam int unsigned CTL_TX_BIT = 3;
    localparam int unsigned CTL_DEFER_BIT = 5;
    localparam logic [31:0] CTL_USED = 32'h0000002C;
    localparam int unsigned DEFER_LIMIT_BITS = 24288;
    // Bit time is 100 ns at 10 Mb/s and 10 ns at 100 Mb/s.
    localparam int unsigned BIT_NS_10M = 100;
    localparam int unsigned BIT_NS_100M = 10;
    localparam int unsigned CLK_NS = 1000000000 / CLK_HZ;
    // A 100 Mb/s bit time is shorter than one clock, so it advances per clock in bit units.
    localparam logic [7:0] BITS_PER_CLK_100M = 8'(CLK_NS / BIT_NS_100M);
    localparam logic [7:0] CLKS_PER_BIT_10M = 8'(BIT_NS_10M / CLK_NS);
    localparam int unsigned EE_LOAD_BYTES = 6;
    localparam logic [7:0] EE_FIRST_ADDR = 8'h01;
    localparam int unsigned IRQ_DEFER_ABORT = 0;
    localparam int unsigned IRQ_EE_DONE = 1;
    localparam logic [31:0] IRQ_USED = 32'h00000003;
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } msa_ee_byte_s;
endpackage

/* File: hdl/msa_station_ctrl.sv */
// Purpose: Station address registers, MAC enables and deferral limit check.
// Assumes: EEPROM controller streams bytes with their addresses after power-on.
// Notes: Avalon-MM slave answers every access one cycle after it is taken.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/100ps
module msa_station_ctrl #(
    parameter int unsigned DEFER_LIMIT = msa_pkg::DEFER_LIMIT_BITS
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire msa_pkg::msa_ee_byte_s ee_byte,
    input wire logic ee_load_done,
    input wire logic speed_100,
    input wire logic tx_frame_ready,
    input wire logic tx_backoff_done,
    input wire logic carrier_sense,
    input wire logic tx_frame_start,
    input wire logic rx_frame_start,
    output logic transmit_path_on,
    output logic receive_path_on,
    output logic tx_go,
    output logic rx_accept,
    output logic tx_defer_abort,
    output logic init_done,
    output logic irq
);
    logic [31:0] ctl;
    logic [31:0] addr_upper;
    logic [31:0] addr_lower;
    logic [31:0] irq_status;
    logic [31:0] irq_mask;
    logic [2:0] crs_sync;
    logic crs_level;
    logic [14:0] defer_bits;
    logic [7:0] bit_div;
    logic deferring;
    logic [31:0] next_readdata;
    logic [31:0] next_upper;
    logic [31:0] next_lower;

    // Merges the enabled byte lanes of a write into the old value.
    // Bits outside the used mask always read back as zero.
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be, input logic [31:0] used);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        be_merge = ((old & ~m) | (wd & m)) & used;
    endfunction

    wire [3:0] reg_idx = avs_address[5:2];
    wire answered = ~avs_waitrequest;
    wire take = (avs_read | avs_write) & ~answered;
    // Writes commit on the edge that samples waitrequest low, as the master expects.
    wire wr = avs_write & answered;
    wire wr_ctl = wr & (reg_idx == msa_pkg::IDX_CONTROL);
    wire wr_upper = wr & (reg_idx == msa_pkg::IDX_ADDR_UPPER);
    wire wr_lower = wr & (reg_idx == msa_pkg::IDX_ADDR_LOWER);
    wire wr_stat = wr & (reg_idx == msa_pkg::IDX_IRQ_STATUS);
    wire wr_mask = wr & (reg_idx == msa_pkg::IDX_IRQ_MASK);
    wire check_on = ctl[msa_pkg::CTL_DEFER_BIT];
    // At 100 Mb/s a clock spans more than one bit time, so the count advances by two bits.
    // At 10 Mb/s a divider spreads one bit over several clocks.
    wire [14:0] step = speed_100 ? 15'(msa_pkg::BITS_PER_CLK_100M) : 15'h0001;
    wire bit_tick = speed_100 | (bit_div == msa_pkg::CLKS_PER_BIT_10M - 8'h01);
    wire defer_now = tx_frame_ready & crs_level & transmit_path_on;
    wire defer_over = defer_bits > 15'(DEFER_LIMIT);
    wire abort_now = check_on & deferring & defer_over;
    wire [31:0] stat_set = {30'h0, ee_load_done & ~init_done, abort_now};
    wire [31:0] byte_mask = be_merge(32'h0, avs_writedata, avs_byteenable, msa_pkg::IRQ_USED);

    // Each EEPROM location lands in the byte lane given by its address offset from EE_FIRST_ADDR.
    // The full byte offset is range checked so that far locations do not alias into a lane.
    wire [7:0] ee_off = ee_byte.addr - msa_pkg::EE_FIRST_ADDR;
    wire [2:0] ee_pos = ee_off[2:0];
    wire ee_hit = ee_byte.valid & ~init_done & (ee_off < 8'(msa_pkg::EE_LOAD_BYTES));
    wire [1:0] ee_lane = ee_pos[1:0];
    wire ee_to_upper = ee_pos[2];

    always_comb
    begin
        next_upper = addr_upper;
        next_lower = addr_lower;
        if (ee_hit & ee_to_upper)
        begin
            next_upper[8 * ee_lane +: 8] = ee_byte.data;
        end
        else if (ee_hit)
        begin
            next_lower[8 * ee_lane +: 8] = ee_byte.data;
        end
        else if (wr_upper)
        begin
            next_upper = be_merge(addr_upper, avs_writedata, avs_byteenable,
                                  msa_pkg::UPPER_USED);
        end
        else if (wr_lower)
        begin
            next_lower = be_merge(addr_lower, avs_writedata, avs_byteenable, 32'hFFFFFFFF);
        end
    end

    // Unmapped indices read as zero.
    always_comb
    begin
        next_readdata = 32'h0;
        unique case (reg_idx)
            msa_pkg::IDX_CONTROL: next_readdata = ctl;
            msa_pkg::IDX_ADDR_UPPER: next_readdata = addr_upper;
            msa_pkg::IDX_ADDR_LOWER: next_readdata = addr_lower;
            msa_pkg::IDX_IRQ_STATUS: next_readdata = irq_status;
            msa_pkg::IDX_IRQ_MASK: next_readdata = irq_mask;
            default: next_readdata = 32'h0;
        endcase
    end

    // Waitrequest is a flop so the bus output carries no decode glitch.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
            ctl <= 32'h0;
            irq_mask <= 32'h0;
        end
        else
        begin
            avs_waitrequest <= ~take;
            avs_readdata <= take ? next_readdata : avs_readdata;
            ctl <= wr_ctl ? be_merge(ctl, avs_writedata, avs_byteenable, msa_pkg::CTL_USED) : ctl;
            irq_mask <= wr_mask ? byte_mask : irq_mask;
        end
    end

    // The station address keeps its reset pattern until the loader or the host writes it.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            addr_upper <= msa_pkg::UPPER_RESET;
            addr_lower <= msa_pkg::LOWER_RESET;
            init_done <= 1'b0;
            irq_status <= 32'h0;
        end
        else
        begin
            addr_upper <= next_upper;
            addr_lower <= next_lower;
            init_done <= init_done | ee_load_done;
            // A new event wins over a clear in the same cycle.
            irq_status <= (irq_status & ~(wr_stat ? byte_mask : 32'h0)) | stat_set;
        end
    end

    // Carrier sense is asynchronous; a new level counts once the two late stages agree.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            crs_sync <= 3'h0;
            crs_level <= 1'b0;
        end
        else
        begin
            crs_sync <= {crs_sync[1:0], carrier_sense};
            crs_level <= (crs_sync[2] == crs_sync[1]) ? crs_sync[2] : crs_level;
        end
    end

    // A break in the hold-off, a finished back-off or an abort restarts the count.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            defer_bits <= 15'h0;
            bit_div <= 8'h0;
            deferring <= 1'b0;
        end
        else if (!defer_now | tx_backoff_done | abort_now)
        begin
            defer_bits <= 15'h0;
            bit_div <= 8'h0;
            deferring <= 1'b0;
        end
        else
        begin
            deferring <= 1'b1;
            bit_div <= bit_tick ? 8'h0 : bit_div + 8'h01;
            defer_bits <= (bit_tick & ~defer_over) ? defer_bits + step : defer_bits;
        end
    end

    // Every output leaves from a flop so the far side sees clean levels.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            transmit_path_on <= 1'b0;
            receive_path_on <= 1'b0;
            tx_go <= 1'b0;
            rx_accept <= 1'b0;
            tx_defer_abort <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            transmit_path_on <= ctl[msa_pkg::CTL_TX_BIT];
            receive_path_on <= ctl[msa_pkg::CTL_RX_BIT];
            tx_go <= tx_frame_start & ctl[msa_pkg::CTL_TX_BIT] & ~crs_level;
            rx_accept <= rx_frame_start & ctl[msa_pkg::CTL_RX_BIT];
            tx_defer_abort <= abort_now;
            irq <= |(irq_status & irq_mask);
        end
    end

    // Bus handshake checks.
    a_waitrequest_one: assert property (@(posedge clk) disable iff (!rst_n)
        (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("Slave did not answer in one cycle.");

    a_wait_idle_high: assert property (@(posedge clk) disable iff (!rst_n)
        !(avs_read || avs_write) |=> avs_waitrequest)
        else $error("Slave answered without a request.");

    // Enable checks.
    a_tx_gated_off: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(ctl[msa_pkg::CTL_TX_BIT]) |-> !tx_go)
        else $error("Frame sent with transmitter disabled.");

    a_rx_gated_off: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(ctl[msa_pkg::CTL_RX_BIT]) |-> !rx_accept)
        else $error("Frame accepted with receiver disabled.");

    a_tx_path_copy: assert property (@(posedge clk) disable iff (!rst_n)
        transmit_path_on == $past(ctl[msa_pkg::CTL_TX_BIT]))
        else $error("Transmit enable output lags its control bit.");

    a_rx_path_copy: assert property (@(posedge clk) disable iff (!rst_n)
        receive_path_on == $past(ctl[msa_pkg::CTL_RX_BIT]))
        else $error("Receive enable output lags its control bit.");

    a_tx_go_req: assert property (@(posedge clk) disable iff (!rst_n)
        tx_go |-> $past(tx_frame_start))
        else $error("Frame sent without a start request.");

    a_tx_go_carrier: assert property (@(posedge clk) disable iff (!rst_n)
        crs_level |=> !tx_go)
        else $error("Frame sent over an active carrier.");

    a_rx_accept_req: assert property (@(posedge clk) disable iff (!rst_n)
        rx_accept |-> $past(rx_frame_start))
        else $error("Frame accepted without a start request.");

    a_ctl_reserved: assert property (@(posedge clk) disable iff (!rst_n)
        (ctl & ~msa_pkg::CTL_USED) == 32'h0)
        else $error("Control reserved bits set.");

    // Deferral checks.
    a_no_abort_off: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(check_on) |-> !tx_defer_abort)
        else $error("Deferral abort with check disabled.");

    a_abort_limit: assert property (@(posedge clk) disable iff (!rst_n)
        abort_now |-> defer_bits > 15'(DEFER_LIMIT))
        else $error("Abort before the deferral limit.");

    a_abort_status: assert property (@(posedge clk) disable iff (!rst_n)
        tx_defer_abort |-> irq_status[msa_pkg::IRQ_DEFER_ABORT])
        else $error("Deferral abort not flagged in status.");

    a_status_reserved: assert property (@(posedge clk) disable iff (!rst_n)
        (irq_status & ~msa_pkg::IRQ_USED) == 32'h0)
        else $error("Status reserved bits set.");

    a_defer_restart: assert property (@(posedge clk) disable iff (!rst_n)
        tx_backoff_done |=> defer_bits == 15'h0)
        else $error("Deferral timer kept time across attempts.");

    a_abort_restart: assert property (@(posedge clk) disable iff (!rst_n)
        tx_defer_abort |-> defer_bits == 15'h0)
        else $error("Deferral timer kept time after an abort.");

    a_no_defer_count: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(defer_now) |-> defer_bits == 15'h0)
        else $error("Deferral counted without carrier hold-off.");

    // Station address checks.
    a_upper_reserved: assert property (@(posedge clk) disable iff (!rst_n)
        addr_upper[31:16] == 16'h0)
        else $error("Upper register reserved bits set.");

    a_upper_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_upper && !ee_hit && avs_byteenable == 4'hF
        |=> addr_upper == ($past(avs_writedata) & 32'h0000FFFF))
        else $error("Upper register write lost.");

    a_lower_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_lower && !ee_hit && avs_byteenable == 4'hF
        |=> addr_lower == $past(avs_writedata))
        else $error("Lower register write lost.");

    a_ee_lower_byte: assert property (@(posedge clk) disable iff (!rst_n)
        ee_hit && !ee_to_upper && ee_lane == 2'h0
        |=> addr_lower[7:0] == $past(ee_byte.data))
        else $error("First EEPROM byte not in lower bits 7:0.");

    a_ee_upper_byte: assert property (@(posedge clk) disable iff (!rst_n)
        ee_hit && ee_to_upper && ee_lane == 2'h1
        |=> addr_upper[15:8] == $past(ee_byte.data))
        else $error("Sixth EEPROM byte not in upper bits 15:8.");

    a_init_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        init_done |=> init_done)
        else $error("Initialisation flag dropped.");

    a_ee_ignored: assert property (@(posedge clk) disable iff (!rst_n)
        init_done && !wr_lower |=> $stable(addr_lower))
        else $error("Lower register changed after initialisation.");

    // Main scenarios.

    c_abort_seen: cover property (@(posedge clk) disable iff (!rst_n) tx_defer_abort);
    c_ee_load: cover property (@(posedge clk) disable iff (!rst_n) ee_hit ##[1:20] ee_load_done);
    c_irq_raise: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
    c_tx_frame: cover property (@(posedge clk) disable iff (!rst_n) tx_go);
    c_host_write: cover property (@(posedge clk) disable iff (!rst_n) wr_lower);
endmodule

/* File: sim/msa_ee_model.sv */
// Purpose: Far-side model of the configuration EEPROM controller.
// Assumes: Bytes stream one per clock after start, then a done pulse.
// Notes: An unprogrammed part only pulses done.
`timescale 1ns/100ps
module msa_ee_model (
    input wire logic clk,
    input wire logic start,
    input wire logic programmed,
    input wire logic [47:0] mac,
    output msa_pkg::msa_ee_byte_s ee_byte,
    output logic ee_load_done
);
    int step = -1;
    initial
    begin
        ee_byte = '0;
        ee_load_done = 1'h0;
    end
    // Between bytes the data lines toggle so stale values never look valid.
    always @(posedge clk)
    begin
        ee_byte.valid <= 1'h0;
        ee_byte.data <= ~ee_byte.data;
        ee_load_done <= 1'h0;
        if (start)
            step <= 0;
        else if (step >= 0 && step < 6)
        begin
            ee_byte.valid <= programmed;
            ee_byte.addr <= 8'(step + 1);
            ee_byte.data <= mac[47 - 8 * step -: 8];
            step <= step + 1;
        end
        else if (step == 6)
        begin
            ee_load_done <= 1'h1;
            step <= -1;
        end
    end
endmodule

/* File: sim/tb.sv */
// Purpose: Self-checking bench for the station address and deferral block.
// Assumes: Deferral limit shortened to 20 bits.
// Notes: Register access over Avalon-MM; expectations derive from the address.
`timescale 1ns/100ps
module tb;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [5:0] avs_address = 6'h0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    msa_pkg::msa_ee_byte_s ee_byte;
    logic ee_load_done, ee_start = 1'h0, ee_prog = 1'h0;
    logic speed_100 = 1'h0, tx_frame_ready = 1'h0, tx_backoff_done = 1'h0;
    logic carrier_sense = 1'h0, tx_frame_start = 1'h0, rx_frame_start = 1'h0;
    logic transmit_path_on, receive_path_on, tx_go, rx_accept, tx_defer_abort, init_done, irq;
    logic [47:0] mac = 48'h123456789ABC;
    int mismatches = 0;
    int comparisons = 0;
    int n;
    always #12.5 clk = ~clk;
    msa_station_ctrl #(.DEFER_LIMIT(20)) u_dut (.clk(clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ee_byte(ee_byte), .ee_load_done(ee_load_done),
        .speed_100(speed_100), .tx_frame_ready(tx_frame_ready),
        .tx_backoff_done(tx_backoff_done), .carrier_sense(carrier_sense),
        .tx_frame_start(tx_frame_start), .rx_frame_start(rx_frame_start),
        .transmit_path_on(transmit_path_on), .receive_path_on(receive_path_on), .tx_go(tx_go),
        .rx_accept(rx_accept), .tx_defer_abort(tx_defer_abort), .init_done(init_done),
        .irq(irq));
    msa_ee_model u_ee (.clk(clk), .start(ee_start), .programmed(ee_prog), .mac(mac),
        .ee_byte(ee_byte), .ee_load_done(ee_load_done));
    task automatic final_report();
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic give_up(input int cnt, input int lim);
        if (cnt >= lim)
        begin
            mismatches++;
            $display("ERROR at %0t: wait timed out", $time);
            final_report();
        end
    endtask
    // The request is held until the edge at which waitrequest is low.
    task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd,
        output logic [31:0] rd);
        int k;
        k = 0;
        avs_address <= {idx, 2'h0};
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (avs_waitrequest !== 1'h0 && k < 40);
        if (avs_waitrequest !== 1'h0)
            give_up(40, 40);
        rd = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] idx, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'h1, idx, d, unused);
    endtask
    task automatic rd(input logic [3:0] idx, input logic [31:0] exp, input string what);
        logic [31:0] v;
        bus(1'h0, idx, 32'h0, v);
        chk(v, exp, what);
    endtask
    task automatic do_reset();
        rst_n <= 1'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
    endtask
    task automatic ee_load(input logic prog);
        int k;
        k = 0;
        ee_prog <= prog;
        ee_start <= 1'h1;
        @(posedge clk);
        ee_start <= 1'h0;
        while (init_done !== 1'h1 && k < 50)
        begin
            @(posedge clk);
            k++;
        end
        give_up(k, 50);
    endtask
    task automatic t_defaults();
        rd(msa_pkg::IDX_ADDR_UPPER, 32'h0000FFFF, "upper reset");
        rd(msa_pkg::IDX_ADDR_LOWER, 32'h0FFFFFFF, "lower reset");
        rd(4'hF, 32'h0, "unmapped read");
        ee_load(1'h0);
        rd(msa_pkg::IDX_ADDR_LOWER, 32'h0FFFFFFF, "no eeprom lower");
    endtask
    task automatic t_eeprom();
        do_reset();
        ee_load(1'h1);
        rd(msa_pkg::IDX_ADDR_LOWER, {mac[23:16], mac[31:24], mac[39:32], mac[47:40]}, "lo");
        rd(msa_pkg::IDX_ADDR_UPPER, {16'h0, mac[7:0], mac[15:8]}, "upper load");
        chk(32'(irq), 32'h0, "irq masked");
        wr(msa_pkg::IDX_IRQ_MASK, 32'h2);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h1, "irq raised");
        wr(msa_pkg::IDX_IRQ_STATUS, 32'h2);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0, "irq cleared");
        rd(msa_pkg::IDX_IRQ_STATUS, 32'h0, "status cleared");
    endtask
    task automatic t_host();
        wr(msa_pkg::IDX_ADDR_UPPER, 32'hFFFFFFFF);
        rd(msa_pkg::IDX_ADDR_UPPER, 32'h0000FFFF, "upper reserved");
        wr(msa_pkg::IDX_ADDR_LOWER, 32'hA5C3_5A3C);
        rd(msa_pkg::IDX_ADDR_LOWER, 32'hA5C3_5A3C, "lower write");
    endtask
    task automatic t_paths();
        logic [31:0] ctl [3] = '{32'h0, 32'h8, 32'h4};
        foreach (ctl[i])
        begin
            wr(msa_pkg::IDX_CONTROL, ctl[i]);
            tx_frame_start <= 1'h1;
            rx_frame_start <= 1'h1;
            @(posedge clk);
            tx_frame_start <= 1'h0;
            rx_frame_start <= 1'h0;
            @(posedge clk);
            chk(32'(tx_go), 32'(ctl[i][3]), "tx go");
            chk(32'(transmit_path_on), 32'(ctl[i][3]), "tx path");
            chk(32'(receive_path_on), 32'(ctl[i][2]), "rx path");
            chk(32'(rx_accept), 32'(ctl[i][2]), "rx accept");
        end
    endtask
    task automatic defer_run(input logic [31:0] ctl, input logic fast, input int kick,
        input int lo, input int hi);
        wr(msa_pkg::IDX_CONTROL, ctl);
        speed_100 <= fast;
        tx_frame_ready <= 1'h1;
        carrier_sense <= 1'h1;
        n = 0;
        while (tx_defer_abort !== 1'h1 && n < 200)
        begin
            @(posedge clk);
            n++;
            tx_backoff_done <= (n == kick);
        end
        chk(32'(n >= lo && n <= hi), 32'h1, "abort delay");
        carrier_sense <= 1'h0;
        tx_frame_ready <= 1'h0;
        repeat (8) @(posedge clk);
    endtask
    initial
    begin
        do_reset();
        t_defaults();
        t_eeprom();
        t_host();
        t_paths();
        defer_run(32'h28, 1'h1, -1, 8, 25);
        rd(msa_pkg::IDX_IRQ_STATUS, 32'h1, "abort status");
        defer_run(32'h28, 1'h0, -1, 75, 110);
        defer_run(32'h28, 1'h0, 40, 115, 199);
        defer_run(32'h08, 1'h0, -1, 200, 200);
        final_report();
    end
endmodule
